//--- rtl/ufc_enh_cfg.sv
// Operation
// RULE1 - Enhanced enable clear blocks writes to INTERRUPT_ENABLE_REG 7:4, FIFO_CONTROL_REG 5:4, MODEM_CONTROL_REG 7:5.
// RULE2 - Low four enhanced feature bits select software flow mode.
// RULE3 - Special detect compares received characters with second stop; match flags INTERRUPT_IDENT_REG bit 4.
// RULE4 - Auto RTS raises RTS at halt level, lowers at resume level.
// RULE5 - Auto CTS halts transmitter while CTS input is high.
// RULE6 - Baud divisor is sixteen bits, high byte and low byte registers.
// RULE7 - Divisor writes accepted only while sleep enable is clear.
// RULE8 - Flow threshold holds halt level low nibble, resume level high nibble.
// RULE9 - Flow threshold writable only with enhanced enable and MODEM_CONTROL_REG bit 6.
// RULE10 - Software keeps halt above resume; hardware does not check.
// RULE11 - Trigger register holds TX spaces low, RX characters high, level over four.
// RULE12 - Trigger register writable only with enhanced enable and MODEM_CONTROL_REG bit 6.
// RULE13 - Zero trigger field uses FIFO control level, nonzero overrides it.
// RULE14 - Ready bits 0 and 1 show enough TX free spaces per channel.
// RULE15 - Ready bits 4 and 5 show RX above trigger or timeout.
// RULE16 - Ready register shows live status; bits 3:2 and 7:6 read zero.
// RULE17 - Ready register read-only at address 7 with select, MODEM_CONTROL_REG bit 2, no loopback.
// RULE18 - MODEM_CONTROL_REG bit 6 opens threshold and trigger registers.
// RULE19 - MODEM_CONTROL_REG bit 4 enters internal loopback.
// RULE20 - INTERRUPT_ENABLE_REG bit 4 enables sleep mode.
// RULE21 - Each threshold field times four gives bytes for comparison.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_enh_cfg
    import ufc_pkg::*;
#(
    parameter int NCH = 2                  // Channel count
)(
    input  wire logic          clock,          // 10 MHz system clock
    input  wire logic          nrst,           // Synchronous reset, active low
    input  wire ufc_bus_t      bus,            // Host parallel bus
    output logic [7:0]         rdata,          // Read data, held until next read
    input  wire ufc_chan_in_t  chan_in [NCH],  // Per-channel FIFO and line status
    output ufc_chan_out_t      chan_out [NCH]  // Per-channel configuration
);

    logic [7:0]    lcr_reg   [NCH];
    logic [7:0]    efr_reg   [NCH];
    logic [7:0]    ier_reg   [NCH];
    logic [7:0]    fcr_reg   [NCH];
    logic [7:0]    mcr_reg   [NCH];
    logic [7:0]    dll_reg   [NCH];
    logic [7:0]    dlh_reg   [NCH];
    logic [7:0]    tcr_reg   [NCH];
    logic [7:0]    tlr_reg   [NCH];
    logic [7:0]    xoff2_reg [NCH];
    logic          spec_reg  [NCH];
    ufc_rts_t      rts_reg   [NCH];
    ufc_rts_t      rts_next  [NCH];
    logic          wr_d_reg;
    logic          rd_d_reg;
    logic [7:0]    rdata_reg;
    ufc_chan_out_t out_reg   [NCH];
    ufc_level_t    tx_trig   [NCH];
    ufc_level_t    rx_trig   [NCH];
    logic          tx_ok     [NCH];
    logic          rx_ok     [NCH];
    logic          wr_pulse;
    logic          rd_pulse;
    logic          rd_ch;
    logic [7:0]    frdy;
    logic [7:0]    rd_mux;

    function automatic logic key_open(input logic [7:0] lcr);
        key_open = (lcr == `UFC_LCR_EFR_KEY);
    endfunction : key_open

    function automatic logic trig_open(input logic [7:0] enhanced_feature_control, input logic [7:0] modem_control_reg);
        trig_open = enhanced_feature_control[`UFC_EFR_ENH] & modem_control_reg[`UFC_MCR_TRIG_EN];
    endfunction : trig_open

    // Locked bits keep their old value unless enhanced functions are on
    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] lock, input logic enh);
        merge = enh ? new_v : ((new_v & ~lock) | (old_v & lock));
    endfunction : merge

    // One access per falling strobe, however long the host holds it low
    assign wr_pulse = ~bus.wr_n & wr_d_reg;
    assign rd_pulse = ~bus.rd_n & rd_d_reg;
    assign rd_ch    = bus.channel_select_n[0];

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_d_reg <= 1'b1;
            rd_d_reg <= 1'b1;
        end else begin
            wr_d_reg <= bus.wr_n;
            rd_d_reg <= bus.rd_n;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_trig
            ufc_trig_sel u_trig (
                .fifo_trigger_level     (tlr_reg[g]),
                .fifo_control_reg     (fcr_reg[g]),
                .tx_trig (tx_trig[g]),
                .rx_trig (rx_trig[g])
            );
            // RULE14 enough TX spaces
            assign tx_ok[g] = (chan_in[g].tx_space >= tx_trig[g]);
            // RULE15 RX above trigger
            assign rx_ok[g] = (chan_in[g].rx_level > rx_trig[g]) | chan_in[g].rx_timeout;
        end
    endgenerate

    // RULE16 live status, unused zero
    assign frdy = {2'b00, rx_ok[1], rx_ok[0], 2'b00, tx_ok[1], tx_ok[0]};

    // Host configuration writes; both channels take a write when both selected
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int c = 0; c < NCH; c++) begin
                lcr_reg[c]   <= `UFC_RST_LCR;
                efr_reg[c]   <= `UFC_RST_REG;
                ier_reg[c]   <= `UFC_RST_REG;
                fcr_reg[c]   <= `UFC_RST_REG;
                mcr_reg[c]   <= `UFC_RST_REG;
                dll_reg[c]   <= `UFC_RST_REG;
                dlh_reg[c]   <= `UFC_RST_REG;
                tcr_reg[c]   <= `UFC_RST_REG;
                tlr_reg[c]   <= `UFC_RST_REG;
                xoff2_reg[c] <= `UFC_RST_REG;
            end
        end else if (wr_pulse) begin
            for (int c = 0; c < NCH; c++) begin
                if (!bus.channel_select_n[c]) begin
                    case (bus.addr)
                        `UFC_OFF_DLL: begin
                            // RULE7 divisor frozen in sleep
                            if (lcr_reg[c][`UFC_LCR_DLAB] && !ier_reg[c][`UFC_IER_SLEEP]) begin
                                dll_reg[c] <= bus.wdata;
                            end
                        end
                        `UFC_OFF_IER: begin
                            if (lcr_reg[c][`UFC_LCR_DLAB]) begin
                                // RULE7 divisor frozen in sleep
                                if (!ier_reg[c][`UFC_IER_SLEEP]) begin
                                    dlh_reg[c] <= bus.wdata;
                                end
                            end else begin
                                // RULE1 enhanced INTERRUPT_ENABLE_REG bits locked
                                ier_reg[c] <= merge(ier_reg[c], bus.wdata, `UFC_IER_ENH_MASK,
                                                    efr_reg[c][`UFC_EFR_ENH]);
                            end
                        end
                        `UFC_OFF_EFR: begin
                            if (key_open(lcr_reg[c])) begin
                                efr_reg[c] <= bus.wdata;
                            end else begin
                                // RULE1 enhanced FIFO_CONTROL_REG bits locked
                                fcr_reg[c] <= merge(fcr_reg[c], bus.wdata, `UFC_FCR_ENH_MASK,
                                                    efr_reg[c][`UFC_EFR_ENH]);
                            end
                        end
                        `UFC_OFF_LCR: begin
                            lcr_reg[c] <= bus.wdata;
                        end
                        `UFC_OFF_MCR: begin
                            if (!key_open(lcr_reg[c])) begin
                                // RULE1 enhanced MODEM_CONTROL_REG bits locked
                                mcr_reg[c] <= merge(mcr_reg[c], bus.wdata, `UFC_MCR_ENH_MASK,
                                                    efr_reg[c][`UFC_EFR_ENH]);
                            end
                        end
                        `UFC_OFF_TCR: begin
                            // RULE9 threshold write gate
                            // RULE18 MODEM_CONTROL_REG bit 6 opens access
                            if (trig_open(efr_reg[c], mcr_reg[c]) && !key_open(lcr_reg[c])) begin
                                tcr_reg[c] <= bus.wdata;
                            end
                        end
                        `UFC_OFF_TLR: begin
                            if (key_open(lcr_reg[c])) begin
                                xoff2_reg[c] <= bus.wdata;
                            // RULE12 trigger write gate
                            end else if (trig_open(efr_reg[c], mcr_reg[c])) begin
                                tlr_reg[c] <= bus.wdata;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // Special character flag; a match in the clearing cycle survives
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int c = 0; c < NCH; c++) begin
                spec_reg[c] <= 1'b0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                // RULE3 second stop match
                if (efr_reg[c][`UFC_EFR_SPEC] && chan_in[c].rx_vld &&
                    chan_in[c].rx_char == xoff2_reg[c]) begin
                    spec_reg[c] <= 1'b1;
                end else if (rd_pulse && !bus.channel_select_n[c] && (rd_ch == c[0]) &&
                             bus.addr == `UFC_OFF_EFR && !key_open(lcr_reg[c])) begin
                    spec_reg[c] <= 1'b0;
                end
            end
        end
    end

    // Auto RTS hysteresis; relies on halt above resume
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            rts_next[c] = rts_reg[c];
            if (!efr_reg[c][`UFC_EFR_ARTS]) begin
                rts_next[c] = RTS_RUN;
            end else begin
                case (rts_reg[c])
                    RTS_RUN: begin
                        // RULE4 halt level reached
                        // RULE8 halt low, resume high nibble
                        // RULE21 field times four
                        if (chan_in[c].rx_level >= ufc_quad(tcr_reg[c][3:0])) begin
                            rts_next[c] = RTS_HALT;
                        end
                    end
                    RTS_HALT: begin
                        // RULE4 resume level reached
                        if (chan_in[c].rx_level <= ufc_quad(tcr_reg[c][7:4])) begin
                            rts_next[c] = RTS_RUN;
                        end
                    end
                    default: begin
                        rts_next[c] = RTS_RUN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int c = 0; c < NCH; c++) begin
                rts_reg[c] <= RTS_RUN;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                rts_reg[c] <= rts_next[c];
            end
        end
    end

    // Outputs to the serial side, all registered
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int c = 0; c < NCH; c++) begin
                out_reg[c] <= '0;
                out_reg[c].rts_n <= 1'b1;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                // RULE4 pin follows flow state
                out_reg[c].rts_n <= efr_reg[c][`UFC_EFR_ARTS] ? (rts_reg[c] == RTS_HALT)
                                                             : ~mcr_reg[c][`UFC_MCR_RTS];
                // RULE5 CTS high halts
                out_reg[c].tx_halt <= efr_reg[c][`UFC_EFR_ACTS] & chan_in[c].cts_n;
                // RULE19 internal loopback
                out_reg[c].loopback <= mcr_reg[c][`UFC_MCR_LOOP];
                // RULE20 sleep enable
                out_reg[c].sleep <= ier_reg[c][`UFC_IER_SLEEP];
                // RULE2 software flow select
                out_reg[c].sw_flow_mode <= efr_reg[c][3:0];
                // RULE6 divisor high and low
                out_reg[c].divisor <= {dlh_reg[c], dll_reg[c]};
                out_reg[c].tx_trig <= tx_trig[c];
                out_reg[c].rx_trig <= rx_trig[c];
            end
        end
    end

    assign chan_out = out_reg;

    // Read mux for the lowest selected channel
    always_comb begin
        rd_mux = 8'h00;
        case (bus.addr)
            `UFC_OFF_DLL: begin
                rd_mux = lcr_reg[rd_ch][`UFC_LCR_DLAB] ? dll_reg[rd_ch] : 8'h00;
            end
            `UFC_OFF_IER: begin
                rd_mux = lcr_reg[rd_ch][`UFC_LCR_DLAB] ? dlh_reg[rd_ch] : ier_reg[rd_ch];
            end
            `UFC_OFF_EFR: begin
                if (key_open(lcr_reg[rd_ch])) begin
                    rd_mux = efr_reg[rd_ch];
                end else begin
                    rd_mux = {{2{fcr_reg[rd_ch][`UFC_FCR_FIFO_EN]}}, 1'b0, spec_reg[rd_ch],
                              3'b000, ~spec_reg[rd_ch]};
                end
            end
            `UFC_OFF_LCR: begin
                rd_mux = lcr_reg[rd_ch];
            end
            `UFC_OFF_MCR: begin
                rd_mux = key_open(lcr_reg[rd_ch]) ? 8'h00 : mcr_reg[rd_ch];
            end
            `UFC_OFF_TCR: begin
                rd_mux = trig_open(efr_reg[rd_ch], mcr_reg[rd_ch]) ? tcr_reg[rd_ch] : 8'h00;
            end
            `UFC_OFF_FRDY: begin
                if (key_open(lcr_reg[rd_ch])) begin
                    rd_mux = xoff2_reg[rd_ch];
                // RULE17 ready register access
                end else if (mcr_reg[rd_ch][`UFC_MCR_FRDY] && !mcr_reg[rd_ch][`UFC_MCR_LOOP]) begin
                    rd_mux = frdy;
                end else if (trig_open(efr_reg[rd_ch], mcr_reg[rd_ch])) begin
                    rd_mux = tlr_reg[rd_ch];
                end
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
        end else if (rd_pulse && bus.channel_select_n != 2'b11) begin
            rdata_reg <= rd_mux;
        end
    end

    assign rdata = rdata_reg;

    // Checks on channel 0
    logic wr0;
    logic rd0;
    assign wr0 = wr_pulse & ~bus.channel_select_n[0];
    assign rd0 = rd_pulse & ~bus.channel_select_n[0];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    ier_lock_a: assert property ( // RULE1
        wr0 && bus.addr == `UFC_OFF_IER && !lcr_reg[0][`UFC_LCR_DLAB] && !efr_reg[0][`UFC_EFR_ENH]
        |=> ier_reg[0][7:4] == $past(ier_reg[0][7:4]))
        else $error("locked INTERRUPT_ENABLE_REG bits changed");

    div_lock_a: assert property ( // RULE7
        wr0 && bus.addr == `UFC_OFF_DLL && lcr_reg[0][`UFC_LCR_DLAB] && ier_reg[0][`UFC_IER_SLEEP]
        |=> $stable(dll_reg[0]))
        else $error("divisor written in sleep");

    tcr_gate_a: assert property ( // RULE9
        wr0 && bus.addr == `UFC_OFF_TCR && !trig_open(efr_reg[0], mcr_reg[0])
        |=> $stable(tcr_reg[0]))
        else $error("threshold written while closed");

    tlr_gate_a: assert property ( // RULE12
        wr0 && bus.addr == `UFC_OFF_TLR && !key_open(lcr_reg[0]) && !trig_open(efr_reg[0], mcr_reg[0])
        |=> $stable(tlr_reg[0]))
        else $error("trigger written while closed");

    spec_set_a: assert property ( // RULE3
        efr_reg[0][`UFC_EFR_SPEC] && chan_in[0].rx_vld && chan_in[0].rx_char == xoff2_reg[0]
        |=> spec_reg[0])
        else $error("special match not flagged");

    rts_halt_a: assert property ( // RULE4
        efr_reg[0][`UFC_EFR_ARTS] && rts_reg[0] == RTS_RUN &&
        chan_in[0].rx_level >= ufc_quad(tcr_reg[0][3:0]) && $stable(efr_reg[0])
        |=> rts_reg[0] == RTS_HALT ##1 chan_out[0].rts_n)
        else $error("RTS not raised at halt level");

    cts_halt_a: assert property ( // RULE5
        efr_reg[0][`UFC_EFR_ACTS] && chan_in[0].cts_n |=> chan_out[0].tx_halt)
        else $error("transmit not halted on CTS");

    frdy_read_a: assert property ( // RULE16
        rd0 && bus.addr == `UFC_OFF_FRDY && !key_open(lcr_reg[0]) &&
        mcr_reg[0][`UFC_MCR_FRDY] && !mcr_reg[0][`UFC_MCR_LOOP]
        |=> rdata[3:2] == 2'b00 && rdata[7:6] == 2'b00 && rdata[0] == $past(tx_ok[0])
            && rdata[4] == $past(rx_ok[0]))
        else $error("ready register read wrong");

    div_out_a: assert property ( // RULE6
        ##1 chan_out[0].divisor == {$past(dlh_reg[0]), $past(dll_reg[0])})
        else $error("divisor output mismatch");

    trig_over_a: assert property ( // RULE13
        tlr_reg[0][7:4] != 4'h0 |=> chan_out[0].rx_trig == ufc_quad($past(tlr_reg[0][7:4])))
        else $error("trigger field not used");

endmodule : ufc_enh_cfg

//--- rtl/ufc_cfg.svh
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

// Register offsets on the 3-bit host address
`define UFC_OFF_DLL      3'h0
`define UFC_OFF_DLH      3'h1
`define UFC_OFF_IER      3'h1
`define UFC_OFF_EFR      3'h2
`define UFC_OFF_FCR      3'h2
`define UFC_OFF_LCR      3'h3
`define UFC_OFF_MCR      3'h4
`define UFC_OFF_TCR      3'h6
`define UFC_OFF_TLR      3'h7
`define UFC_OFF_FRDY     3'h7
`define UFC_OFF_XOFF2    3'h7

// Line control value that opens the enhanced register space
`define UFC_LCR_EFR_KEY  8'hBF
`define UFC_LCR_DLAB     7

// Field positions
`define UFC_EFR_ENH      4
`define UFC_EFR_SPEC     5
`define UFC_EFR_ARTS     6
`define UFC_EFR_ACTS     7
`define UFC_IER_SLEEP    4
`define UFC_MCR_RTS      1
`define UFC_MCR_FRDY     2
`define UFC_MCR_LOOP     4
`define UFC_MCR_TRIG_EN  6
`define UFC_FCR_FIFO_EN  0
`define UFC_FCR_TXT_LSB  4
`define UFC_FCR_RXT_LSB  6

// Bits that only move while enhanced functions are enabled
`define UFC_IER_ENH_MASK 8'hF0
`define UFC_FCR_ENH_MASK 8'h30
`define UFC_MCR_ENH_MASK 8'hE0

// Reset values
`define UFC_RST_REG      8'h00
`define UFC_RST_LCR      8'h00

// FIFO control trigger tables, bytes
`define UFC_FCR_TX_TRIG0 7'h08
`define UFC_FCR_TX_TRIG1 7'h10
`define UFC_FCR_TX_TRIG2 7'h20
`define UFC_FCR_TX_TRIG3 7'h38
`define UFC_FCR_RX_TRIG0 7'h08
`define UFC_FCR_RX_TRIG1 7'h10
`define UFC_FCR_RX_TRIG2 7'h38
`define UFC_FCR_RX_TRIG3 7'h3C

`endif

//--- rtl/ufc_pkg.sv
package ufc_pkg;

    typedef logic [6:0] ufc_level_t;

    typedef struct packed {
        logic [1:0] channel_select_n;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ufc_bus_t;

    typedef struct packed {
        ufc_level_t rx_level;
        ufc_level_t tx_space;
        logic       rx_timeout;
        logic       rx_vld;
        logic [7:0] rx_char;
        logic       cts_n;
    } ufc_chan_in_t;

    typedef struct packed {
        logic        rts_n;
        logic        tx_halt;
        logic        loopback;
        logic        sleep;
        logic [3:0]  sw_flow_mode;
        logic [15:0] divisor;
        ufc_level_t  tx_trig;
        ufc_level_t  rx_trig;
    } ufc_chan_out_t;

    typedef enum logic {RTS_RUN, RTS_HALT} ufc_rts_t;

    // Four-bit level field to bytes
    function automatic ufc_level_t ufc_quad(input logic [3:0] field);
        ufc_quad = {1'b0, field, 2'b00};
    endfunction : ufc_quad

endpackage : ufc_pkg

//--- rtl/ufc_trig_sel.sv
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_trig_sel
    import ufc_pkg::*;
(
    input  wire logic [7:0] fifo_trigger_level,     // Trigger level register
    input  wire logic [7:0] fifo_control_reg,     // FIFO control register
    output ufc_level_t      tx_trig, // Effective TX trigger, spaces
    output ufc_level_t      rx_trig  // Effective RX trigger, characters
);

    logic [1:0] tx_code;
    logic [1:0] rx_code;
    ufc_level_t tx_fcr;
    ufc_level_t rx_fcr;

    assign tx_code = fifo_control_reg[`UFC_FCR_TXT_LSB +: 2];
    assign rx_code = fifo_control_reg[`UFC_FCR_RXT_LSB +: 2];

    always_comb begin
        case (tx_code)
            2'h0:    tx_fcr = `UFC_FCR_TX_TRIG0;
            2'h1:    tx_fcr = `UFC_FCR_TX_TRIG1;
            2'h2:    tx_fcr = `UFC_FCR_TX_TRIG2;
            default: tx_fcr = `UFC_FCR_TX_TRIG3;
        endcase
        case (rx_code)
            2'h0:    rx_fcr = `UFC_FCR_RX_TRIG0;
            2'h1:    rx_fcr = `UFC_FCR_RX_TRIG1;
            2'h2:    rx_fcr = `UFC_FCR_RX_TRIG2;
            default: rx_fcr = `UFC_FCR_RX_TRIG3;
        endcase
    end

    // RULE13 zero field falls back
    // RULE11 field holds level over four
    assign tx_trig = (fifo_trigger_level[3:0] == 4'h0) ? tx_fcr : ufc_quad(fifo_trigger_level[3:0]);
    assign rx_trig = (fifo_trigger_level[7:4] == 4'h0) ? rx_fcr : ufc_quad(fifo_trigger_level[7:4]);

endmodule : ufc_trig_sel

//--- dv/ufc_peer_model.sv
`timescale 1ns/10ps
module ufc_peer_model
    import ufc_pkg::*;
(
    input  wire logic            clock,       // System clock
    input  wire logic            nrst,        // Synchronous reset, active low
    input  wire logic [1:0][6:0] rx_goal,     // Target RX occupancy per channel
    input  wire logic [1:0][6:0] tx_free,     // TX free spaces per channel
    input  wire logic [1:0]      timeout,     // RX timeout levels
    input  wire logic [1:0]      cts_pin,     // CTS pin levels, high stops
    output logic                 settled,     // RX levels have reached their goals
    output ufc_chan_in_t         chan_in [2]  // Line side status
);
    logic [1:0][6:0] lvl_reg;

    // One character per cycle, so thresholds are crossed, never jumped
    always_ff @(posedge clock) begin
        for (int c = 0; c < 2; c++) begin
            if (!nrst)
                lvl_reg[c] <= 7'h00;
            else if (lvl_reg[c] < rx_goal[c])
                lvl_reg[c] <= lvl_reg[c] + 7'h01;
            else if (lvl_reg[c] > rx_goal[c])
                lvl_reg[c] <= lvl_reg[c] - 7'h01;
        end
    end

    always_comb begin
        settled = (lvl_reg == rx_goal);
        for (int c = 0; c < 2; c++) begin
            chan_in[c].rx_level   = lvl_reg[c];
            chan_in[c].tx_space   = tx_free[c];
            chan_in[c].rx_timeout = timeout[c];
            chan_in[c].rx_vld     = nrst && (lvl_reg[c] < rx_goal[c]);
            chan_in[c].rx_char    = {1'b0, lvl_reg[c]};
            chan_in[c].cts_n      = cts_pin[c];
        end
    end
endmodule : ufc_peer_model

//--- dv/test_uart_flow_trigger_config.sv
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module test_uart_flow_trigger_config
    import ufc_pkg::*;
;
    logic            clock = 1'b0;
    logic            nrst = 1'b0;
    ufc_bus_t        bus;
    logic [7:0]      rdata;
    ufc_chan_in_t    chan_in [2];
    ufc_chan_out_t   chan_out [2];
    logic [1:0][6:0] rx_goal;
    logic [1:0][6:0] tx_free;
    logic [1:0]      timeout;
    logic [1:0]      cts_pin;
    logic            settled;
    logic [7:0]      v;
    logic [7:0]      dv;
    logic [7:0]      fifo_trigger_level;
    int              miscompares = 0;
    int              cmp_count = 0;
    int              seed = 41;

    always #50 clock = ~clock;

    ufc_enh_cfg #(.NCH(2)) u_dut (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata),
                                  .chan_in(chan_in), .chan_out(chan_out));
    ufc_peer_model u_peer (.clock(clock), .nrst(nrst), .rx_goal(rx_goal), .tx_free(tx_free),
                           .timeout(timeout), .cts_pin(cts_pin), .settled(settled), .chan_in(chan_in));

    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Strobe low for one edge, then high for one edge before the next access
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus.addr = a;
        bus.wdata = d;
        bus.wr_n = 1'b0;
        @(posedge clock) #1 bus.wr_n = 1'b1;
        @(posedge clock) #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        bus.addr = a;
        bus.rd_n = 1'b0;
        @(posedge clock) #1 bus.rd_n = 1'b1;
        d = rdata;
        @(posedge clock) #1;
    endtask : rd

    task automatic settle();
        int n;
        n = 0;
        @(posedge clock) #1;
        while (settled !== 1'b1 && n < 100) begin
            @(posedge clock) #1;
            n++;
        end
        if (n == 100) begin
            miscompares++;
            close_out();
        end
        repeat (3) @(posedge clock);
        #1;
    endtask : settle

    function automatic logic [6:0] eff(input logic [3:0] f, input logic [6:0] dflt);
        return (f == 4'h0) ? dflt : {1'b0, f, 2'b00};
    endfunction : eff

    function automatic logic [7:0] ready_exp();
        logic [7:0] r;
        r = 8'h00;
        for (int c = 0; c < 2; c++) begin
            r[c] = tx_free[c] >= eff(fifo_trigger_level[3:0], `UFC_FCR_TX_TRIG0);
            r[c + 4] = (rx_goal[c] > eff(fifo_trigger_level[7:4], `UFC_FCR_RX_TRIG0)) || timeout[c];
        end
        return r;
    endfunction : ready_exp

    initial begin
        bus = '{channel_select_n: 2'b00, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, wdata: 8'h00};
        rx_goal = '0;
        tx_free = '0;
        timeout = 2'b00;
        cts_pin = 2'b00;
        repeat (8) @(posedge clock);
        #1 nrst = 1'b1;
        chk("rts_n", 16'h1, chan_out[0].rts_n);
        dv = 8'($random(seed));
        wr(3'h3, 8'h80);
        wr(3'h0, dv);
        wr(3'h1, ~dv);
        chk("divisor", {~dv, dv}, chan_out[1].divisor);
        wr(3'h3, 8'h00);
        wr(3'h1, 8'hF0);
        wr(3'h4, 8'h40);
        wr(3'h7, 8'h55);
        chk("sleep", 16'h0, chan_out[0].sleep);
        chk("tx_trig", 16'h8, chan_out[0].tx_trig);
        wr(3'h3, 8'hBF);
        for (int m = 0; m < 16; m++) begin
            wr(3'h2, {4'h1, 4'(m)});
            chk("flow mode", 16'(m), chan_out[0].sw_flow_mode);
        end
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h44);
        wr(3'h6, 8'h12);
        rd(3'h6, v);
        chk("threshold", 16'h12, v);
        for (int k = 0; k < 8; k++) begin
            fifo_trigger_level = (k == 0) ? 8'h0F : (k == 1) ? 8'hF0 : 8'($random(seed));
            wr(3'h7, fifo_trigger_level);
            chk("tx_trig", eff(fifo_trigger_level[3:0], `UFC_FCR_TX_TRIG0), chan_out[0].tx_trig);
            chk("rx_trig", eff(fifo_trigger_level[7:4], `UFC_FCR_RX_TRIG0), chan_out[1].rx_trig);
            rx_goal = {7'($unsigned($random(seed)) % 65), 7'($unsigned($random(seed)) % 65)};
            tx_free = {7'($unsigned($random(seed)) % 65), 7'($unsigned($random(seed)) % 65)};
            timeout = 2'($random(seed));
            settle();
            rd(3'h7, v);
            chk("ready", ready_exp(), v);
        end
        wr(3'h2, 8'hB0);
        wr(3'h7, 8'h00);
        chk("tx_trig", `UFC_FCR_TX_TRIG3, chan_out[0].tx_trig);
        chk("rx_trig", `UFC_FCR_RX_TRIG2, chan_out[1].rx_trig);
        fifo_trigger_level = 8'h9C;
        wr(3'h7, fifo_trigger_level);
        wr(3'h4, 8'h04);
        wr(3'h6, 8'h77);
        wr(3'h4, 8'h44);
        rd(3'h6, v);
        chk("threshold", 16'h12, v);
        wr(3'h4, 8'h54);
        chk("loopback", 16'h1, chan_out[0].loopback);
        rd(3'h7, v);
        chk("trigger read", fifo_trigger_level, v);
        wr(3'h1, 8'h10);
        chk("sleep", 16'h1, chan_out[0].sleep);
        wr(3'h3, 8'h80);
        wr(3'h0, 8'hA5);
        chk("divisor", {~dv, dv}, chan_out[0].divisor);
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'hD0);
        rx_goal = '0;
        settle();
        cts_pin = 2'b01;
        repeat (2) @(posedge clock);
        #1;
        chk("tx_halt a", 16'h1, chan_out[0].tx_halt);
        chk("tx_halt b", 16'h0, chan_out[1].tx_halt);
        rx_goal = {7'h00, 7'h14};
        settle();
        chk("rts_n a", 16'h1, chan_out[0].rts_n);
        rx_goal = '0;
        settle();
        chk("rts_n a", 16'h0, chan_out[0].rts_n);
        wr(3'h7, 8'h0A);
        wr(3'h2, 8'h30);
        rx_goal = {7'h00, 7'h10};
        settle();
        wr(3'h3, 8'h00);
        rd(3'h2, v);
        chk("special", 16'h10, v);
        rd(3'h2, v);
        chk("special", 16'h01, v);
        close_out();
    end
endmodule : test_uart_flow_trigger_config
